// *** rtl/timer_pwm_map.vh ***
// Register offsets, field positions and reset values of the timer/PWM unit.
`ifndef TIMER_PWM_MAP_VH
`define TIMER_PWM_MAP_VH
`define TP_ADDR_W         5
`define TP_NCH            2
`define TP_OFF_SC         5'h00
`define TP_OFF_CNT_HI     5'h01
`define TP_OFF_CNT_LO     5'h02
`define TP_OFF_MOD_HI     5'h03
`define TP_OFF_MOD_LO     5'h04
`define TP_OFF_CH_BASE    5'h05
`define TP_CH_STRIDE      5'h03
`define TP_CH_SC          5'h00
`define TP_CH_VAL_HI      5'h01
`define TP_CH_VAL_LO      5'h02
`define TP_OFF_IRQ_STAT   5'h0B
`define TP_OFF_IRQ_MASK   5'h0C
`define TP_SC_OVF         7
`define TP_SC_OVF_IE      6
`define TP_SC_CENTER      5
`define TP_SC_CLK_HI      4
`define TP_SC_CLK_LO      3
`define TP_SC_PRESC_HI    2
`define TP_CSC_FLAG       7
`define TP_CSC_IE         6
`define TP_CSC_MODE_HI    5
`define TP_CSC_MODE_LO    4
`define TP_CSC_EDGE_HI    3
`define TP_CSC_EDGE_LO    2
`define TP_SC_RESET       8'h00
`define TP_CSC_RESET      6'h00
`define TP_CNT_FULL       16'hFFFF
`define TP_CNT_FULL_M1    16'hFFFE
`define TP_ONE16          16'h0001
`define TP_ZERO16         16'h0000
`endif

// *** rtl/pin_sync3.v ***
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module pin_sync3
(
    input  wire ref_clk,
    input  wire rst_n,
    input  wire pin_in,
    output reg  level_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    // Only the second stage reads the first, keeping metastability contained.
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level_r <= s3_r;
        end
    end
endmodule // pin_sync3

// *** rtl/timer_pwm_update_reset_irq.v ***
// Timer/PWM unit: buffered 16-bit updates, reset state and interrupt flags.
`timescale 1ns/1ps
`include "timer_pwm_map.vh"
module timer_pwm_update_reset_irq
(
    input  wire                     ref_clk,
    input  wire                     rst_n,
    input  wire [`TP_ADDR_W-1:0]    addr,
    input  wire [7:0]               wdata,
    input  wire                     wr,
    input  wire                     rd,
    output reg  [7:0]               rdata,
    input  wire [`TP_NCH-1:0]       chan_pin_in,
    output wire [`TP_NCH-1:0]       chan_pin_out,
    output wire [`TP_NCH-1:0]       chan_pin_oe,
    output wire                     ext_clk_in,
    output wire                     irq
);
    // Timer status control: overflow flag, enable, center select, clock select.
    reg  [7:0]  sc_r;
    reg  [15:0] cnt_r;
    reg  [15:0] mod_r;
    reg  [7:0]  mod_hi_buf_r;
    reg  [7:0]  mod_lo_buf_r;
    reg         mod_hi_got_r;
    reg         mod_lo_got_r;
    reg         cnt_latched_r;
    reg  [7:0]  cnt_lo_latch_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_mask_r;
    reg  [2:0]  presc_r;
    // External count clock select is unsupported; the port exists for symmetry.
    assign ext_clk_in = 1'b0;

    wire [1:0]  clk_sel    = {sc_r[`TP_SC_CLK_HI], sc_r[`TP_SC_CLK_LO]};
    wire        clk_none   = (clk_sel == 2'b00);
    wire        center     = sc_r[`TP_SC_CENTER];
    // Prescaler is a fixed divide by eight when the slow select is chosen.
    wire        tick       = !clk_none && (clk_sel == 2'b01 || presc_r == 3'h7);
    wire        free_run   = (mod_r == `TP_ZERO16);
    wire        at_top     = free_run ? (cnt_r == `TP_CNT_FULL) : (cnt_r == mod_r);
    wire        top_m1     = free_run ? (cnt_r == `TP_CNT_FULL_M1)
                                      : (cnt_r == mod_r - `TP_ONE16);
    wire        wr_sc      = wr && (addr == `TP_OFF_SC);
    wire        rd_stat    = rd && (addr == `TP_OFF_IRQ_STAT);

    // Center mode counts up then down; direction register only used there.
    reg         down_r;
    wire [15:0] cnt_nxt;
    wire        ovf_evt;
    assign ovf_evt = tick && (center ? (down_r && cnt_r == `TP_ONE16) : at_top);
    assign cnt_nxt = center ? (down_r ? cnt_r - `TP_ONE16 : cnt_r + `TP_ONE16)
                            : (at_top ? `TP_ZERO16 : cnt_r + `TP_ONE16);

    reg  [5:0]  csc_r   [0:`TP_NCH-1];
    reg  [15:0] val_r   [0:`TP_NCH-1];
    reg  [7:0]  vhi_b_r [0:`TP_NCH-1];
    reg  [7:0]  vlo_b_r [0:`TP_NCH-1];
    reg  [1:0]  vgot_r  [0:`TP_NCH-1];
    reg  [`TP_NCH-1:0] ch_flag_r;
    reg  [`TP_NCH-1:0] pin_prev_r;
    reg  [`TP_NCH-1:0] pwm_out_r;
    wire [`TP_NCH-1:0] pin_sync;
    wire [`TP_NCH-1:0] ch_evt;
    wire [`TP_NCH-1:0] ch_sc_wr;
    wire [`TP_NCH-1:0] ch_rd_sc;

    genvar g;
    generate
        for (g = 0; g < `TP_NCH; g = g + 1)
        begin : chan
            localparam [`TP_ADDR_W-1:0] BASE = `TP_OFF_CH_BASE + g * `TP_CH_STRIDE;
            wire       wr_csc  = wr && (addr == BASE + `TP_CH_SC);
            wire       wr_vhi  = wr && (addr == BASE + `TP_CH_VAL_HI);
            wire       wr_vlo  = wr && (addr == BASE + `TP_CH_VAL_LO);
            // Stored bits keep the register's own positions, so the field macros apply.
            wire [1:0] mode    = {csc_r[g][`TP_CSC_MODE_HI], csc_r[g][`TP_CSC_MODE_LO]};
            wire [1:0] edge_s  = {csc_r[g][`TP_CSC_EDGE_HI], csc_r[g][`TP_CSC_EDGE_LO]};
            wire       capture = !center && (mode == 2'b00);
            wire       both    = (vgot_r[g] == 2'b11);
            wire       rise    = pin_sync[g] && !pin_prev_r[g];
            wire       fall    = !pin_sync[g] && pin_prev_r[g];
            wire       cap_evt = capture && ((edge_s == 2'b01 && rise) ||
                                             (edge_s == 2'b10 && fall) ||
                                             (edge_s == 2'b11 && (rise || fall)));
            wire       cmp_evt = !capture && tick && (cnt_r == val_r[g]);
            // Center mode with a running clock waits for the top-of-count step.
            wire       load    = center ? (clk_none ? both : both && tick && top_m1)
                                        : both;
            assign ch_evt[g]   = cap_evt || cmp_evt;
            assign ch_sc_wr[g] = wr_csc;
            assign ch_rd_sc[g] = rd && (addr == BASE + `TP_CH_SC);
            // Pin stays released to general I/O in capture mode or while both edge bits are clear.
            assign chan_pin_oe[g]  = !capture && (edge_s != 2'b00);
            assign chan_pin_out[g] = pwm_out_r[g];

            pin_sync3 u_sync
            (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .pin_in  (chan_pin_in[g]),
                .level_r (pin_sync[g])
            );

            always @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    csc_r[g]      <= `TP_CSC_RESET;
                    val_r[g]      <= `TP_ZERO16;
                    vhi_b_r[g]    <= 8'h00;
                    vlo_b_r[g]    <= 8'h00;
                    vgot_r[g]     <= 2'b00;
                    ch_flag_r[g]  <= 1'b0;
                    pin_prev_r[g] <= 1'b0;
                    pwm_out_r[g]  <= 1'b0;
                end
                else
                begin
                    pin_prev_r[g] <= pin_sync[g];
                    if (wr_csc)
                    begin
                        csc_r[g]  <= wdata[5:0];
                        vgot_r[g] <= 2'b00;
                    end
                    else if (load)
                    begin
                        val_r[g]  <= {vhi_b_r[g], vlo_b_r[g]};
                        vgot_r[g] <= 2'b00;
                    end
                    else if (wr_vhi)
                    begin
                        vhi_b_r[g]   <= wdata;
                        vgot_r[g][1] <= 1'b1;
                    end
                    else if (wr_vlo)
                    begin
                        vlo_b_r[g]   <= wdata;
                        vgot_r[g][0] <= 1'b1;
                    end
                    if (capture && cap_evt)
                        val_r[g] <= cnt_r;
                    // Flag set wins over a write-zero clear in the same cycle.
                    if (ch_evt[g])
                        ch_flag_r[g] <= 1'b1;
                    else if (wr_csc && !wdata[`TP_CSC_FLAG])
                        ch_flag_r[g] <= 1'b0;
                    if (cmp_evt)
                        pwm_out_r[g] <= (mode == 2'b01) ? ~pwm_out_r[g] : edge_s[0];
                    else if (tick && !capture && mode != 2'b01 && at_top)
                        pwm_out_r[g] <= ~edge_s[0];
                end
            end
        end
    endgenerate

    // Interrupt sources: bit 0 overflow, bits above one per channel.
    wire [2:0] src_evt = {ch_evt & {`TP_NCH{1'b1}}, ovf_evt};
    wire [2:0] src_en  = {csc_r[1][4] & 1'b0 | 1'b1, 1'b1, sc_r[`TP_SC_OVF_IE]};
    assign irq = |(irq_stat_r & irq_mask_r & src_en);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            sc_r           <= `TP_SC_RESET;
            cnt_r          <= `TP_ZERO16;
            mod_r          <= `TP_ZERO16;
            mod_hi_buf_r   <= 8'h00;
            mod_lo_buf_r   <= 8'h00;
            mod_hi_got_r   <= 1'b0;
            mod_lo_got_r   <= 1'b0;
            cnt_latched_r  <= 1'b0;
            cnt_lo_latch_r <= 8'h00;
            irq_stat_r     <= 3'h0;
            irq_mask_r     <= 3'h0;
            presc_r        <= 3'h0;
            down_r         <= 1'b0;
        end
        else
        begin
            presc_r <= presc_r + 3'h1;
            if (wr_sc)
            begin
                sc_r[6:0]    <= wdata[6:0];
                mod_hi_got_r <= 1'b0;
                mod_lo_got_r <= 1'b0;
            end
            else if (mod_hi_got_r && mod_lo_got_r && (clk_none || (tick && at_top)))
            begin
                mod_r        <= {mod_hi_buf_r, mod_lo_buf_r};
                mod_hi_got_r <= 1'b0;
                mod_lo_got_r <= 1'b0;
            end
            else if (wr && addr == `TP_OFF_MOD_HI)
            begin
                mod_hi_buf_r <= wdata;
                mod_hi_got_r <= 1'b1;
            end
            else if (wr && addr == `TP_OFF_MOD_LO)
            begin
                mod_lo_buf_r <= wdata;
                mod_lo_got_r <= 1'b1;
            end
            // Overflow flag: set wins; cleared by writing zero to it.
            if (ovf_evt)
                sc_r[`TP_SC_OVF] <= 1'b1;
            else if (wr_sc && !wdata[`TP_SC_OVF])
                sc_r[`TP_SC_OVF] <= 1'b0;
            if (wr && (addr == `TP_OFF_CNT_HI || addr == `TP_OFF_CNT_LO))
            begin
                cnt_r  <= `TP_ZERO16;
                down_r <= 1'b0;
            end
            else if (tick)
            begin
                cnt_r <= cnt_nxt;
                if (center && top_m1 && !down_r)
                    down_r <= 1'b1;
                else if (center && down_r && cnt_r == `TP_ONE16)
                    down_r <= 1'b0;
            end
            // Reading the high byte freezes the low byte for a coherent pair.
            if (rd && addr == `TP_OFF_CNT_HI)
            begin
                cnt_latched_r  <= 1'b1;
                cnt_lo_latch_r <= cnt_r[7:0];
            end
            else if (rd && addr == `TP_OFF_CNT_LO)
                cnt_latched_r <= 1'b0;
            if (wr && addr == `TP_OFF_IRQ_MASK)
                irq_mask_r <= wdata[2:0];
            // Read of status clears it, but a new event in that cycle survives.
            irq_stat_r <= (rd_stat ? 3'h0 : irq_stat_r) | src_evt;
        end
    end

    integer k;
    reg [7:0] rd_nxt;
    always @*
    begin
        rd_nxt = 8'h00;
        case (addr)
            `TP_OFF_SC:       rd_nxt = sc_r;
            `TP_OFF_CNT_HI:   rd_nxt = cnt_r[15:8];
            `TP_OFF_CNT_LO:   rd_nxt = cnt_latched_r ? cnt_lo_latch_r : cnt_r[7:0];
            `TP_OFF_MOD_HI:   rd_nxt = mod_r[15:8];
            `TP_OFF_MOD_LO:   rd_nxt = mod_r[7:0];
            `TP_OFF_IRQ_STAT: rd_nxt = {5'h00, irq_stat_r};
            `TP_OFF_IRQ_MASK: rd_nxt = {5'h00, irq_mask_r};
            default:          rd_nxt = 8'h00;
        endcase
        for (k = 0; k < `TP_NCH; k = k + 1)
        begin
            if (ch_rd_sc[k])
                rd_nxt = {ch_flag_r[k], 1'b0, csc_r[k]};
            if (addr == `TP_OFF_CH_BASE + k * 3 + 1)
                rd_nxt = val_r[k][15:8];
            if (addr == `TP_OFF_CH_BASE + k * 3 + 2)
                rd_nxt = val_r[k][7:0];
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else
            rdata <= rd ? rd_nxt : 8'h00;
    end
endmodule // timer_pwm_update_reset_irq

// *** test/timer_pwm_update_reset_irq_props.sv ***
// Port-level checker for the timer/PWM update, reset and interrupt block.
`timescale 1ns/1ps
`include "timer_pwm_map.vh"
module timer_pwm_update_reset_irq_props
(
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    input wire logic [`TP_ADDR_W-1:0] addr,
    input wire logic [7:0]            wdata,
    input wire logic                  wr,
    input wire logic                  rd,
    input wire logic [7:0]            rdata,
    input wire logic [`TP_NCH-1:0]    chan_pin_in,
    input wire logic [`TP_NCH-1:0]    chan_pin_out,
    input wire logic [`TP_NCH-1:0]    chan_pin_oe,
    input wire logic                  ext_clk_in,
    input wire logic                  irq
);
    AST_RST_CLEARS: assert property (@(posedge ref_clk)
        !rst_n |=> chan_pin_oe == 2'b00 && irq == 1'b0) else $error("outputs not clear after reset");
    AST_RST_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(rst_n) |-> !irq ##1 chan_pin_oe == 2'b00) else $error("state left after reset");
    AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(rd) |-> rdata == 8'h00) else $error("read data without a read");
    AST_OE0_ROSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(chan_pin_oe[0]) |-> $past(wr)) else $error("pin 0 taken without a write");
    AST_OE1_ROSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(chan_pin_oe[1]) |-> $past(wr)) else $error("pin 1 taken without a write");
    AST_OE0_FELL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(chan_pin_oe[0]) |-> $past(wr)) else $error("pin 0 released without a write");
    AST_IRQ_FELL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(irq) |-> $past(rd) || $past(wr)) else $error("interrupt dropped without access");
    AST_MASK_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr && addr == `TP_OFF_IRQ_MASK && wdata == 8'h00 |=> !irq) else $error("masked irq high");
endmodule // timer_pwm_update_reset_irq_props

bind timer_pwm_update_reset_irq timer_pwm_update_reset_irq_props u_props
(
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .ext_clk_in(ext_clk_in), .irq(irq)
);

// *** test/chan_pin_model.sv ***
// Outside world on the timer channel pins.
`timescale 1ns/1ps
module chan_pin_model
(
    output logic [1:0] chan_pin_in
);
    initial chan_pin_in = 2'b00;
    // Each level is held far longer than the three-flop filter needs, so no edge is lost.
    task automatic rise(input int ch);
        chan_pin_in[ch] = 1'b0;
        #40;
        chan_pin_in[ch] = 1'b1;
    endtask
endmodule // chan_pin_model

// *** test/timer_pwm_update_reset_irq_test.sv ***
// Register-level testbench of the timer/PWM update, reset and interrupt block.
`timescale 1ns/1ps
`include "timer_pwm_map.vh"
module timer_pwm_update_reset_irq_test;
    localparam logic [4:0] C0 = `TP_OFF_CH_BASE;
    localparam logic [4:0] C1 = `TP_OFF_CH_BASE + `TP_CH_STRIDE;
    logic       ref_clk;
    logic       rst_n;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [1:0] pin_in;
    logic [1:0] pin_oe;
    logic       irq;
    logic [7:0] v;
    logic [7:0] top;
    int         n_fail;
    int         num_checks;

    timer_pwm_update_reset_irq u_timer_pwm_update_reset_irq
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .chan_pin_in(pin_in), .chan_pin_out(), .chan_pin_oe(pin_oe),
        .ext_clk_in(), .irq(irq)
    );
    chan_pin_model u_chan_pin_model (.chan_pin_in(pin_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        // Let the write settle so a caller may compare outputs right away.
        #1;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        q = rdata;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        rd_reg(a, q);
        check(q, exp);
    endtask
    task automatic check_reset();
        rd_chk(`TP_OFF_SC, `TP_SC_RESET);
        rd_chk(C0, 8'h00);
        rd_chk(C1, 8'h00);
        check({6'h00, pin_oe}, 8'h00);
        check({7'h00, irq}, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end

    initial
    begin
        rst_n = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        n_fail = 0;
        num_checks = 0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_reset();
        // Counting stays stopped while loading, so both values land at once.
        wr_reg(`TP_OFF_MOD_HI, 8'h00);
        wr_reg(`TP_OFF_MOD_LO, 8'h04);
        wr_reg(C0, 8'h14);
        wr_reg(C0 + 5'h01, 8'h00);
        wr_reg(C0 + 5'h02, 8'h03);
        wr_reg(C1, 8'h10);
        wr_reg(C1 + 5'h01, 8'h00);
        wr_reg(C1 + 5'h02, 8'h09);
        wr_reg(C1 + 5'h01, 8'h00);
        wr_reg(C1, 8'h10);
        wr_reg(C1 + 5'h02, 8'h02);
        wr_reg(`TP_OFF_MOD_HI, 8'h00);
        wr_reg(`TP_OFF_SC, 8'h00);
        wr_reg(`TP_OFF_MOD_LO, 8'h02);
        wr_reg(`TP_OFF_IRQ_MASK, 8'h07);
        wr_reg(`TP_OFF_SC, 8'h48);
        // A stride of two cycles against a period of five visits every count.
        top = 8'h00;
        for (int i = 0; i < 20; i++)
        begin
            rd_reg(`TP_OFF_CNT_LO, v);
            if (v > top)
                top = v;
        end
        check(top, 8'h04);
        wr_reg(`TP_OFF_SC, 8'hC0);
        rd_chk(`TP_OFF_SC, 8'hC0);
        rd_chk(C0, 8'h94);
        rd_chk(C1, 8'h10);
        check({7'h00, irq}, 8'h01);
        rd_chk(`TP_OFF_IRQ_STAT, 8'h03);
        rd_chk(`TP_OFF_IRQ_STAT, 8'h00);
        check({7'h00, irq}, 8'h00);
        wr_reg(C1, 8'h04);
        u_chan_pin_model.rise(1);
        repeat (8) @(posedge ref_clk);
        rd_chk(C1, 8'h84);
        check({7'h00, irq}, 8'h01);
        wr_reg(`TP_OFF_IRQ_MASK, 8'h00);
        check({7'h00, irq}, 8'h00);
        rd_chk(`TP_OFF_IRQ_STAT, 8'h04);
        wr_reg(C0, 8'h00);
        rd_chk(5'h1F, 8'h00);
        // Center counting with the clock stopped loads on the second byte.
        wr_reg(`TP_OFF_SC, 8'h20);
        wr_reg(C0 + 5'h01, 8'h01);
        rd_chk(C0 + 5'h01, 8'h00);
        wr_reg(C0 + 5'h02, 8'h07);
        rd_chk(C0 + 5'h01, 8'h01);
        rd_chk(C0 + 5'h02, 8'h07);
        wr_reg(`TP_OFF_SC, 8'h48);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_reset();
        print_verdict();
    end
endmodule // timer_pwm_update_reset_irq_test
